// file: rtl/abt_agu.sv
/*
  Address generator: bit-reversed X write addressing, 24-bit program address
  construction for table reads, program-space-visibility reads and the
  program counter. Control registers over an Avalon-MM slave with waitrequest.
  Assumes the pipeline presents one-cycle request pulses synchronous to clk_sys
  and the program memory answers a read strobe with a pm_valid pulse later.
*/
module abt_agu
  import abt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  // avalon-mm slave
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // effective address requests from the pipeline
  input wire logic agen_req,
  input wire logic agen_write,
  input wire logic agen_xspace,
  input wire logic agen_byte,
  input wire logic [2:0] agen_mode,
  input wire logic [3:0] agen_reg,
  input wire logic [15:0] agen_ptr,
  input wire logic [15:0] agen_offset,
  output logic agen_done,
  output logic [15:0] agen_ea,
  output logic [15:0] agen_ptr_next,
  output logic agen_bitrev,
  // table reads
  input wire logic tbl_req,
  input wire logic tbl_high,
  input wire logic tbl_byte,
  input wire logic [15:0] tbl_ea,
  output logic tbl_done,
  output logic [15:0] tbl_data,
  output logic tbl_cfg,
  // program space visibility
  input wire logic psv_req,
  input wire logic psv_write,
  input wire logic [23:0] psv_addr,
  output logic psv_done,
  output logic [15:0] psv_data,
  output logic psv_err,
  output logic mem_busy,
  // program memory port
  output logic pm_rd,
  output logic [23:0] pm_addr,
  input wire logic [23:0] pm_rdata,
  input wire logic pm_valid,
  // program counter
  input wire logic pc_load,
  input wire logic [23:0] pc_load_value,
  input wire logic pc_advance,
  output logic [23:0] pc
);

  // ==========================================================
  // helpers

  function automatic logic [15:0] rev16(input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      r[i] = v[15 - i];
    end
    return r;
  endfunction

  // reversed-carry add: the pointer stays in normal order, only the pivot is
  // treated as reversed; the carries run from the MSB down toward the LSB
  function automatic logic [15:0] rev_add(input logic [15:0] ptr, input logic [14:0] pivot);
    logic [15:0] s;
    logic [15:0] t;
    s = 16'(rev16(ptr) + rev16({pivot, 1'b0})); // R5 R20 R11
    t = rev16(s);
    // a carry that runs off the reversed top lands in bit 0, dropped for word data
    return {t[15:1], 1'b0}; // R7
  endfunction

  // byte-lane merge for a 16-bit register held in the low half of the word
  function automatic logic [15:0] be_merge16(input logic [15:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // table data lane selection and phantom byte
  function automatic logic [15:0] tbl_extract(input logic [23:0] w, input logic hi,
                                              input logic bmode, input logic bsel);
    logic [15:0] r;
    r = 16'h0000;
    if (!hi && !bmode) begin
      r = w[15:0]; // R15
    end else if (!hi) begin
      r = {8'h00, bsel ? w[15:8] : w[7:0]}; // R16
    end else if (!bmode) begin
      r = {8'h00, w[23:16]}; // R17
    end else begin
      r = bsel ? 16'h0000 : {8'h00, w[23:16]}; // R18
    end
    return r;
  endfunction

  // ==========================================================
  // state

  typedef struct packed {
    logic [15:0] brc;
    logic [7:0] page;
    logic [15:0] mode;
    logic av_wait;
    logic [31:0] av_rdata;
    logic ag_done;
    logic [15:0] ag_ea;
    logic [15:0] ag_ptr;
    logic ag_rev;
    abt_state_t st;
    logic pm_rd;
    logic [23:0] pm_addr;
    logic hi;
    logic bmode;
    logic bsel;
    logic cfg;
    logic t_done;
    logic [15:0] t_data;
    logic p_done;
    logic [15:0] p_data;
    logic p_err;
    logic p_err_seen;
    logic [23:0] pc;
    // busy kept as its own flop so the pipeline stall sees no state decode
    logic busy;
  } abt_regs_t;

  abt_regs_t s_q;
  abt_regs_t s_d;

  logic av_req;
  logic av_fire;
  logic rev_cond;
  logic [15:0] step;
  logic [15:0] ptr_mod;

  assign av_req = avs_read | avs_write;
  // the access completes in the cycle waitrequest is seen low
  assign av_fire = av_req & ~s_q.av_wait;

  // bit reversal qualifies only on word X writes in increment modes through
  // the selected pointer; this bypasses modulo correction downstream
  assign rev_cond = agen_write & agen_xspace & ~agen_byte // R1 R8
                  & s_q.brc[ABT_BRC_EN_BIT] // R2
                  & (s_q.mode[ABT_MODE_SEL_LSB +: 4] != ABT_SEL_NONE) // R2
                  & (agen_reg == s_q.mode[ABT_MODE_SEL_LSB +: 4])
                  & ((agen_mode == ABT_AM_PRE_INC) | (agen_mode == ABT_AM_POST_INC)); // R2 R8 R9

  // normal modified pointer
  // decrement modes negate the offset; the 16-bit wrap is intended
  assign step = (agen_mode == ABT_AM_POST_DEC || agen_mode == ABT_AM_PRE_DEC) ? 16'(-agen_offset)
                                                                              : agen_offset;
  assign ptr_mod = 16'(agen_ptr + step);

  // ==========================================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.ag_done = 1'b0;
    s_d.t_done = 1'b0;
    s_d.p_done = 1'b0;
    s_d.p_err = 1'b0;
    s_d.pm_rd = 1'b0;

    // bus slave: one wait cycle, then a single completion cycle
    s_d.av_wait = 1'b1;
    if (av_req && s_q.av_wait) begin
      s_d.av_wait = 1'b0;
      unique case (avs_address)
        ABT_OFS_BRC: s_d.av_rdata = {16'h0000, s_q.brc}; // R3
        ABT_OFS_PAGE: s_d.av_rdata = {24'h000000, s_q.page};
        ABT_OFS_MODE: s_d.av_rdata = {16'h0000, s_q.mode};
        ABT_OFS_STATUS: s_d.av_rdata = {28'h0000000, s_q.p_err_seen, s_q.cfg, s_q.st};
      endcase
    end
    if (av_fire && avs_write) begin
      unique case (avs_address)
        ABT_OFS_BRC: s_d.brc = be_merge16(s_q.brc, avs_writedata, avs_byteenable); // R3
        ABT_OFS_PAGE: begin
          if (avs_byteenable[0]) begin
            s_d.page = avs_writedata[7:0];
          end
        end
        ABT_OFS_MODE: s_d.mode = be_merge16(s_q.mode, avs_writedata, avs_byteenable);
        ABT_OFS_STATUS: begin
          // writing 1 to bit 3 clears the sticky error, a new error wins
          if (avs_byteenable[0] && avs_writedata[3]) begin
            s_d.p_err_seen = 1'b0;
          end
        end
      endcase
    end

    // effective address generation, answered one cycle after the request
    if (agen_req) begin
      s_d.ag_done = 1'b1;
      s_d.ag_rev = rev_cond;
      if (rev_cond) begin
        // normal offset ignored, pivot added instead
        s_d.ag_ptr = rev_add(agen_ptr, s_q.brc[ABT_BRC_PIVOT_W - 1:0]); // R6
        s_d.ag_ea = (agen_mode == ABT_AM_PRE_INC) ? rev_add(agen_ptr, s_q.brc[ABT_BRC_PIVOT_W - 1:0])
                                                  : {agen_ptr[15:1], 1'b0}; // R7
      end else begin
        unique case (agen_mode)
          ABT_AM_POST_INC, ABT_AM_POST_DEC: begin
            s_d.ag_ea = agen_ptr;
            s_d.ag_ptr = ptr_mod;
          end
          ABT_AM_PRE_INC, ABT_AM_PRE_DEC: begin
            s_d.ag_ea = ptr_mod;
            s_d.ag_ptr = ptr_mod;
          end
          ABT_AM_INDEXED, ABT_AM_LITERAL: begin
            s_d.ag_ea = 16'(agen_ptr + agen_offset);
            s_d.ag_ptr = agen_ptr;
          end
          ABT_AM_DIRECT, ABT_AM_INDIRECT: begin
            s_d.ag_ea = agen_ptr;
            s_d.ag_ptr = agen_ptr;
          end
        endcase
      end
    end

    // program memory sequencer; table reads win over visibility reads
    // requests that arrive while busy are dropped: the pipeline waits for done
    unique case (s_q.st)
      ABT_ST_IDLE: begin
        if (tbl_req) begin
          s_d.st = ABT_ST_TBL;
          s_d.pm_rd = 1'b1;
          s_d.pm_addr = {s_q.page, tbl_ea}; // R13 R14
          s_d.cfg = s_q.page[ABT_PAGE_CFG_BIT]; // R13
          s_d.hi = tbl_high;
          s_d.bmode = tbl_byte;
          s_d.bsel = tbl_ea[0];
        end else if (psv_req && psv_write) begin
          s_d.p_err = 1'b1; // R19
          s_d.p_done = 1'b1;
          s_d.p_err_seen = 1'b1;
        end else if (psv_req) begin
          s_d.st = ABT_ST_PSV;
          s_d.pm_rd = 1'b1;
          s_d.pm_addr = psv_addr;
        end
      end
      ABT_ST_TBL: begin
        if (pm_valid) begin
          s_d.st = ABT_ST_IDLE;
          s_d.t_done = 1'b1;
          s_d.t_data = tbl_extract(pm_rdata, s_q.hi, s_q.bmode, s_q.bsel);
        end
      end
      ABT_ST_PSV: begin
        if (pm_valid) begin
          s_d.st = ABT_ST_IDLE;
          s_d.p_done = 1'b1;
          s_d.p_data = pm_rdata[15:0]; // R19
        end
      end
      default: s_d.st = ABT_ST_IDLE;
    endcase

    // program counter: bit 0 always clear, one step per program word
    if (pc_load) begin
      s_d.pc = {pc_load_value[23:1], 1'b0};
    end else if (pc_advance) begin
      s_d.pc = 24'(s_q.pc + ABT_PC_STEP); // R12
    end

    // busy follows the sequencer state in the same edge
    s_d.busy = (s_d.st != ABT_ST_IDLE);
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.brc <= ABT_BRC_RST;
      s_q.page <= ABT_PAGE_RST;
      s_q.mode <= ABT_MODE_RST;
      s_q.av_wait <= 1'b1;
      s_q.st <= ABT_ST_IDLE;
      s_q.pc <= ABT_PC_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign avs_readdata = s_q.av_rdata;
  assign avs_waitrequest = s_q.av_wait;
  assign agen_done = s_q.ag_done;
  assign agen_ea = s_q.ag_ea;
  assign agen_ptr_next = s_q.ag_ptr;
  assign agen_bitrev = s_q.ag_rev;
  assign tbl_done = s_q.t_done;
  assign tbl_data = s_q.t_data;
  assign tbl_cfg = s_q.cfg;
  assign psv_done = s_q.p_done;
  assign psv_data = s_q.p_data;
  assign psv_err = s_q.p_err;
  assign mem_busy = s_q.busy;
  assign pm_rd = s_q.pm_rd;
  assign pm_addr = s_q.pm_addr;
  assign pc = s_q.pc;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_rev_xwrite_only: assert property (agen_req && !(agen_write && agen_xspace) |=> !agen_bitrev) // R1
    else $error("bit reversal on a read or Y access");
  a_rev_disable: assert property (agen_req && (s_q.mode[11:8] == ABT_SEL_NONE || !s_q.brc[15])
                                  |=> agen_done && !agen_bitrev) // R2
    else $error("bit reversal while disabled");
  a_rev_lsb_clear: assert property (agen_done && agen_bitrev |-> agen_ea[0] == 1'b0 && agen_ptr_next[0] == 1'b0) // R7
    else $error("bit reversed address lsb set");
  a_rev_byte_normal: assert property (agen_req && agen_byte |=> !agen_bitrev) // R8
    else $error("bit reversal on byte write");
  a_rev_pivot_add: assert property (agen_req && rev_cond |=>
                                    agen_ptr_next == rev_add($past(agen_ptr), $past(s_q.brc[14:0]))) // R6
    else $error("bit reversed pointer not pointer plus pivot");
  a_rev_pre_ea: assert property (agen_req && rev_cond && agen_mode == ABT_AM_PRE_INC |=> agen_ea == agen_ptr_next) // R6
    else $error("pre increment reversed address differs from new pointer");
  a_rev_sel_match: assert property (agen_req && agen_reg != s_q.mode[11:8] |=> !agen_bitrev) // R2
    else $error("bit reversal through a pointer that is not selected");
  a_tbl_page_addr: assert property (s_q.st == ABT_ST_IDLE && tbl_req |=>
                                    pm_rd && pm_addr == {$past(s_q.page), $past(tbl_ea)} && mem_busy) // R13
    else $error("table address not page and ea");
  a_tbl_phantom: assert property (tbl_done && s_q.hi |-> tbl_data[15:8] == 8'h00) // R17
    else $error("phantom byte not zero");
  a_tbl_hi_sel1: assert property (s_q.st == ABT_ST_TBL && pm_valid && s_q.hi && s_q.bmode && s_q.bsel
                                  |=> tbl_done && tbl_data == 16'h0000) // R18
    else $error("high byte select 1 not zero");
  a_tbl_low_word: assert property (s_q.st == ABT_ST_TBL && pm_valid && !s_q.hi && !s_q.bmode
                                   |=> tbl_data == $past(pm_rdata[15:0])) // R15
    else $error("low word table data wrong");
  a_psv_readonly: assert property (s_q.st == ABT_ST_IDLE && !tbl_req && psv_req && psv_write
                                   |=> psv_err && !pm_rd && !mem_busy) // R19
    else $error("write through visibility window reached memory");
  a_pc_step: assert property (pc_advance && !pc_load |=> pc == 24'($past(pc) + 24'h000002)) // R12
    else $error("program counter did not step by two");
  // register bus timing: exactly one wait state, then waitrequest back up
  a_bus_answer: assert property (av_req && avs_waitrequest |-> ##1 !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not within one cycle");

  c_rev_write: cover property (agen_done && agen_bitrev);
  c_tbl_cfg: cover property (tbl_done && tbl_cfg && s_q.hi);
  c_psv_read: cover property (psv_done && !psv_err);
  c_bus_write: cover property (av_fire && avs_write && avs_address == ABT_OFS_BRC);
  c_psv_refused: cover property (psv_done && psv_err);

endmodule

// file: rtl/abt_pkg.sv
/*
  Constants, field layouts, encodings and state types for the address generator
  (bit-reversed write addressing and table/program-space read construction).
  Assumes a single 25 MHz system clock and an Avalon-MM host reaching the
  control registers through word-indexed addresses.
*/
// Operation
// R1: bit-reversed addressing only for X-space data writes, never reads or Y space
// R2: active only if pointer select not 1111, enable set, pre/post increment mode
// R3: control register: enable in bit 15, 15-bit pivot in bits 14 to 0
// R4: software aligns a 2^N byte buffer on an address with N low zeros
// R5: only the modifier is treated reversed; pointer and destination stay normal
// R6: in bit-reversed mode pointer plus pivot replaces the normal increment offset
// R7: word data assumed: pivot scaled to bytes, effective address LSB forced zero
// R8: byte writes or other modes give ordinary addresses even when enabled
// R9: bit reversal takes precedence over modulo on the same pointer for writes
// R10: software avoids indirect read through reverse pointer right after control write
// R11: 16-entry buffer index sequence equals the 4-bit reversal of the index
// R12: program space 24 bits, data space 16 bits, program counter steps by two
// R13: table address is page and effective address; page bit 7 picks config space
// R14: table accesses need no word alignment; config space reads permitted
// R15: low table read in word mode returns program bits 15 to 0
// R16: low table read byte mode: select 1 upper byte, 0 lower byte, into low byte
// R17: high table read word mode: bits 23 to 16 in low byte, upper byte zero
// R18: high table read byte mode: bits 23 to 16 for select 0, zero for select 1
// R19: program space seen through data space is read only, low word only
// R20: reversed add carries run from MSB toward LSB: reverse, add, reverse back
package abt_pkg;

  // ==========================================================
  // register map (word index on the Avalon-MM slave)
  localparam logic [1:0] ABT_OFS_BRC = 2'h0;
  localparam logic [1:0] ABT_OFS_PAGE = 2'h1;
  localparam logic [1:0] ABT_OFS_MODE = 2'h2;
  localparam logic [1:0] ABT_OFS_STATUS = 2'h3;

  // ==========================================================
  // field layouts
  localparam int ABT_BRC_EN_BIT = 15;
  localparam int ABT_BRC_PIVOT_W = 15;
  localparam int ABT_MODE_SEL_LSB = 8;
  localparam int ABT_PAGE_CFG_BIT = 7;
  localparam logic [3:0] ABT_SEL_NONE = 4'hf;

  // ==========================================================
  // reset values
  localparam logic [15:0] ABT_BRC_RST = 16'h0000;
  localparam logic [7:0] ABT_PAGE_RST = 8'h00;
  localparam logic [15:0] ABT_MODE_RST = 16'h0f00;
  localparam logic [23:0] ABT_PC_RST = 24'h000000;

  // ==========================================================
  // timing: program counter step per program word
  localparam logic [23:0] ABT_PC_STEP = 24'h000002;

  // ==========================================================
  // addressing modes issued by the pipeline
  localparam logic [2:0] ABT_AM_DIRECT = 3'h0;
  localparam logic [2:0] ABT_AM_INDIRECT = 3'h1;
  localparam logic [2:0] ABT_AM_POST_INC = 3'h2;
  localparam logic [2:0] ABT_AM_POST_DEC = 3'h3;
  localparam logic [2:0] ABT_AM_PRE_INC = 3'h4;
  localparam logic [2:0] ABT_AM_PRE_DEC = 3'h5;
  localparam logic [2:0] ABT_AM_INDEXED = 3'h6;
  localparam logic [2:0] ABT_AM_LITERAL = 3'h7;

  // program memory access sequencer
  typedef enum logic [1:0] {
    ABT_ST_IDLE = 2'b00,
    ABT_ST_TBL = 2'b01,
    ABT_ST_PSV = 2'b10
  } abt_state_t;

endpackage

// file: sim/abt_pm_model.sv
/*
  program memory partner: answers each pm_rd with one pm_valid pulse.
  assumes the bench chooses prompt or slow latency through slow.
*/
module abt_pm_model (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic slow,
  input wire logic pm_rd,
  input wire logic [23:0] pm_addr,
  output logic [23:0] pm_rdata,
  output logic pm_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_q;
  logic [23:0] addr_q;
  // contents follow from the address so the bench can predict every word
  function automatic logic [23:0] word_at(input logic [23:0] a);
    return {a[23:16] ^ a[7:0], a[15:0] ^ 16'hc3a5};
  endfunction
  // data toggles outside valid so a stale sample never passes for a match
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 2'h0;
      addr_q <= 24'h0;
      pm_valid <= 1'b0;
      pm_rdata <= 24'h0;
    end else begin
      pm_valid <= 1'b0;
      pm_rdata <= ~pm_rdata;
      if (pm_rd && !slow) begin
        pm_valid <= 1'b1;
        pm_rdata <= word_at(pm_addr);
      end else if (pm_rd) begin
        cnt_q <= 2'h2;
        addr_q <= pm_addr;
      end else if (cnt_q != 2'h0) begin
        cnt_q <= cnt_q - 2'h1;
        if (cnt_q == 2'h1) begin
          pm_valid <= 1'b1;
          pm_rdata <= word_at(addr_q);
        end
      end
    end
  end
endmodule

// file: sim/abt_agu_bench.sv
/*
  self-checking bench for the address generator with a program memory model.
  assumes the hand-over timing: one wait state on the register bus, done one
  cycle after an address request, table/psv reads done after pm_valid, a refused psv write done one cycle after its request.
*/
module abt_agu_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import abt_pkg::*;
  logic clk_sys = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, pm_slow = 1'b0;
  logic [1:0] avs_address = 2'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic agen_req = 1'b0, agen_write = 1'b0, agen_xspace = 1'b0, agen_byte = 1'b0;
  logic [2:0] agen_mode = 3'h0;
  logic [3:0] agen_reg = 4'h0;
  logic [15:0] agen_ptr = 16'h0, agen_offset = 16'h0, agen_ea, agen_ptr_next, tbl_data, psv_data, v, nx;
  logic tbl_req = 1'b0, tbl_high = 1'b0, tbl_byte = 1'b0, psv_req = 1'b0, psv_write = 1'b0;
  logic [15:0] tbl_ea = 16'h0, cfg_brc = 16'h0, cfg_mode = 16'h0f00, seed = 16'h0011;
  logic [23:0] psv_addr = 24'h0, pc_load_value = 24'h0, pm_addr, pm_rdata, pc;
  logic pc_load = 1'b0, pc_advance = 1'b0, avs_waitrequest, agen_done, agen_bitrev, tbl_done, tbl_cfg;
  logic psv_done, psv_err, mem_busy, pm_rd, pm_valid;
  logic [7:0] cfg_page = 8'h0;
  int n_errors = 0, compares = 0;
  // ==========================================================
  // design and partner
  abt_agu abt_agu_inst (.clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h3),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .agen_req(agen_req),
    .agen_write(agen_write), .agen_xspace(agen_xspace), .agen_byte(agen_byte), .agen_mode(agen_mode),
    .agen_reg(agen_reg), .agen_ptr(agen_ptr), .agen_offset(agen_offset), .agen_done(agen_done),
    .agen_ea(agen_ea), .agen_ptr_next(agen_ptr_next), .agen_bitrev(agen_bitrev), .tbl_req(tbl_req),
    .tbl_high(tbl_high), .tbl_byte(tbl_byte), .tbl_ea(tbl_ea), .tbl_done(tbl_done), .tbl_data(tbl_data),
    .tbl_cfg(tbl_cfg), .psv_req(psv_req), .psv_write(psv_write), .psv_addr(psv_addr),
    .psv_done(psv_done), .psv_data(psv_data), .psv_err(psv_err), .mem_busy(mem_busy), .pm_rd(pm_rd),
    .pm_addr(pm_addr), .pm_rdata(pm_rdata), .pm_valid(pm_valid), .pc_load(pc_load),
    .pc_load_value(pc_load_value), .pc_advance(pc_advance), .pc(pc));
  abt_pm_model abt_pm_model_inst (.clk_sys(clk_sys), .reset_n(reset_n), .slow(pm_slow), .pm_rd(pm_rd),
    .pm_addr(pm_addr), .pm_rdata(pm_rdata), .pm_valid(pm_valid));
  // 25 MHz system clock
  always #20 clk_sys = ~clk_sys;
  // ==========================================================
  // helpers
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction
  function automatic logic [15:0] rev16(input logic [15:0] a);
    for (int i = 0; i < 16; i++) rev16[i] = a[15 - i];
  endfunction
  function automatic logic [23:0] pmw(input logic [23:0] a);
    return {a[23:16] ^ a[7:0], a[15:0] ^ 16'hc3a5};
  endfunction
  // expected {ea, ptr_next, bitrev} for the current control settings
  function automatic logic [32:0] exp_agen(input logic w, x, b, input logic [2:0] m, input logic [3:0] r,
      input logic [15:0] p, o);
    logic [15:0] np;
    logic rv;
    rv = w && x && !b && cfg_brc[15] && cfg_mode[11:8] != 4'hf && r == cfg_mode[11:8] &&
      (m == ABT_AM_PRE_INC || m == ABT_AM_POST_INC);
    np = rev16(rev16(p) + rev16({cfg_brc[14:0], 1'b0})) & 16'hfffe;
    if (rv) return {(m == ABT_AM_PRE_INC) ? np : {p[15:1], 1'b0}, np, 1'b1};
    case (m)
      ABT_AM_POST_INC: return {p, p + o, 1'b0};
      ABT_AM_POST_DEC: return {p, p - o, 1'b0};
      ABT_AM_PRE_INC: return {p + o, p + o, 1'b0};
      ABT_AM_PRE_DEC: return {p - o, p - o, 1'b0};
      ABT_AM_INDEXED, ABT_AM_LITERAL: return {p + o, p, 1'b0};
      default: return {p, p, 1'b0};
    endcase
  endfunction
  function automatic logic [15:0] exp_tbl(input logic [23:0] a, input logic h, b);
    logic [23:0] w;
    w = pmw(a);
    if (!h) return b ? {8'h00, a[0] ? w[15:8] : w[7:0]} : w[15:0];
    return (b && a[0]) ? 16'h0000 : {8'h00, w[23:16]};
  endfunction
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one avalon access, held until waitrequest is sampled low
  task automatic av(input logic wr, input logic [1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 20) n_errors++;
  endtask
  task automatic agen(input logic w, x, b, input logic [2:0] m, input logic [3:0] r, input logic [15:0] p, o);
    @(posedge clk_sys);
    agen_req <= 1'b1;
    {agen_write, agen_xspace, agen_byte, agen_mode, agen_reg, agen_ptr, agen_offset} <= {w, x, b, m, r, p, o};
    @(posedge clk_sys);
    agen_req <= 1'b0;
    @(negedge clk_sys);
    chk(agen_done, 1'b1);
    chk({agen_ea, agen_ptr_next, agen_bitrev}, exp_agen(w, x, b, m, r, p, o));
    nx = agen_ptr_next;
  endtask
  // table read (t=1) or psv access (t=0); the model latency is drawn at random
  task automatic mem(input logic t, h, b, w, input logic [23:0] a);
    int n;
    n = 0;
    @(posedge clk_sys);
    pm_slow <= seed[3];
    {tbl_req, tbl_high, tbl_byte, tbl_ea} <= {t, h, b, a[15:0]};
    {psv_req, psv_write, psv_addr} <= {!t, w, a};
    @(posedge clk_sys);
    tbl_req <= 1'b0;
    psv_req <= 1'b0;
    do begin
      @(negedge clk_sys);
      n++;
      if (n == 1) chk(mem_busy, !(w && !t));
    end while (tbl_done !== 1'b1 && psv_done !== 1'b1 && n < 20);
    if (n >= 20) n_errors++;
    if (t) chk({tbl_cfg, tbl_data}, {cfg_page[7], exp_tbl({cfg_page, a[15:0]}, h, b)});
    else chk({psv_err, w ? 16'h0 : psv_data}, {w, w ? 16'h0 : 16'(pmw(a))});
  endtask
  task automatic print_verdict();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog: the whole sequence needs well under 20000 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    print_verdict();
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    av(1'b0, ABT_OFS_BRC, 32'h0);
    chk(q, 32'h0);
    av(1'b0, ABT_OFS_MODE, 32'h0);
    chk(q, 32'h0f00);
    av(1'b1, ABT_OFS_BRC, 32'hffff8008);
    av(1'b0, ABT_OFS_BRC, 32'h0);
    chk(q, 32'h8008);
    // 16-entry word buffer at an aligned base walks the 4-bit reversed order
    cfg_brc = 16'h8008;
    cfg_mode = 16'h0300;
    av(1'b1, ABT_OFS_MODE, {16'h0, cfg_mode});
    nx = 16'h1000;
    for (int k = 0; k < 16; k++) begin
      agen(1'b1, 1'b1, 1'b0, ABT_AM_POST_INC, 4'h3, nx, 16'h0002);
      chk(nx, 16'h1000 + {11'h0, rev16(16'(k + 1)) >> 12, 1'b0});
    end
    // random requests under enabled, pointer-off and disabled settings
    for (int c = 0; c < 3; c++) begin
      cfg_brc = (c == 2) ? 16'h0040 : {1'b1, 15'(rnd() & 16'h01fe)};
      cfg_mode = (c == 1) ? 16'h0f00 : 16'h0300;
      av(1'b1, ABT_OFS_BRC, {16'h0, cfg_brc});
      av(1'b1, ABT_OFS_MODE, {16'h0, cfg_mode});
      for (int i = 0; i < 24; i++) begin
        v = rnd();
        agen(v[0] | v[1], v[2] | v[3], v[4] & v[5], v[10:8], v[6] ? 4'h3 : (c == 1 ? 4'hf : v[15:12]), rnd(), rnd());
      end
    end
    // table reads in both spaces, every width, half and byte select
    for (int pg = 0; pg < 2; pg++) begin
      cfg_page = {pg[0], 7'(rnd())};
      av(1'b1, ABT_OFS_PAGE, {24'h0, cfg_page});
      av(1'b0, ABT_OFS_PAGE, 32'h0);
      chk(q, {24'h0, cfg_page});
      for (int k = 0; k < 8; k++) mem(1'b1, k[2], k[1], 1'b0, {8'h0, rnd() & 16'hfffe | 16'(k[0])});
    end
    // program space seen through data space: read gives low word, write refused
    mem(1'b0, 1'b0, 1'b0, 1'b0, {rnd(), rnd() & 16'h00ff} >> 8);
    mem(1'b0, 1'b0, 1'b0, 1'b1, 24'h001234);
    av(1'b0, ABT_OFS_STATUS, 32'h0);
    chk(q[3], 1'b1);
    av(1'b1, ABT_OFS_STATUS, 32'h8);
    av(1'b0, ABT_OFS_STATUS, 32'h0);
    chk(q[3], 1'b0);
    // program counter: load wins over advance, each advance adds two
    @(posedge clk_sys);
    pc_load <= 1'b1;
    pc_advance <= 1'b1;
    pc_load_value <= 24'h7ffff7;
    @(posedge clk_sys);
    pc_load <= 1'b0;
    @(negedge clk_sys);
    chk(pc, 24'h7ffff6);
    @(posedge clk_sys);
    pc_advance <= 1'b0;
    @(negedge clk_sys);
    chk(pc, 24'h7ffff8);
    print_verdict();
  end
endmodule
